// File: hw/bmi_bitop.v
// Purpose: Single-bit operation and flag update, combinational.
// Assumes: Operands already fetched; caller writes results back.
// Notes: Compare never writes its destination.
`include "bmi_map.vh"

module bmi_bitop (
  input wire [1:0] op,
  input wire [2:0] bitpos,
  input wire [7:0] dst,
  input wire [7:0] src,
  input wire [7:0] cc_in,
  output reg [7:0] res,
  output reg dst_we,
  output reg [7:0] cc_out
);

  reg [7:0] mask;

  always @* begin
    mask = 8'h01 << bitpos;
    res = dst;
    dst_we = 1'b0;
    cc_out = cc_in;
    case (op)
      `BMI_OP_CMP: begin
        // Equal bits set zero, differing bits clear it
        cc_out[`BMI_CC_Z] = ~(dst[0] ^ src[bitpos]);
        cc_out[`BMI_CC_S] = 1'b0;
      end
      `BMI_OP_CPL: begin
        res = dst ^ mask;
        dst_we = 1'b1;
        cc_out[`BMI_CC_Z] = ((dst ^ mask) == 8'h00);
        cc_out[`BMI_CC_S] = 1'b0;
      end
      `BMI_OP_CLR: begin
        res = dst & ~mask;
        dst_we = 1'b1;
      end
      `BMI_OP_SET: begin
        res = dst | mask;
        dst_we = 1'b1;
      end
      default: begin
        res = dst;
      end
    endcase
    // Overflow is left as it was so results stay repeatable
    cc_out[`BMI_CC_V] = cc_in[`BMI_CC_V];
  end

endmodule // bmi_bitop

// File: hw/bmi_core.v
// Purpose: Bit compare, complement, clear and set execution over APB.
// Assumes: One pclk domain; software loads the instruction, then starts it.
// Notes: Register space of 256 bytes plus control words.
//
// Notes on behaviour
// - Compare: 17h, three bytes, six cycles
// - Differing compared bits clear zero flag
// - Byte two: register, bit, selector fields
// - Complement: 57h, two bytes, four cycles
// - Complement: zero from result, sign cleared
// - Clear: 77h selector 0, no flags
// - Set: 77h selector 1, no flags
// - Compare: equal sets zero, sign cleared
`include "bmi_map.vh"

module bmi_core (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg done
);

  ////////////////////////////////////////////////////////////////////////
  // State and registers

  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_WB = 2'h2;

  reg [7:0] regs_r [0:255];
  reg [7:0] cc_r;
  reg [23:0] instr_r;
  reg [1:0] state_r;
  reg [2:0] cnt_r;
  reg [1:0] op_r;
  reg [2:0] bit_r;
  reg [7:0] dst_addr_r;
  reg [7:0] dst_r;
  reg [7:0] src_r;
  reg ill_r;
  reg [1:0] bytes_r;
  reg [2:0] cyc_r;

  wire [`BMI_IDX_W-1:0] idx = paddr[11:2];
  wire setup = psel & ~penable;
  wire wr_en = setup & pwrite;
  wire mem_hit = (idx[9:8] == 2'b00) && (idx != `BMI_IDX_CC);
  wire cc_hit = (idx == `BMI_IDX_CC);
  wire mapped = mem_hit | cc_hit | (idx == `BMI_IDX_INSTR) |
                (idx == `BMI_IDX_CTRL) | (idx == `BMI_IDX_STAT);

  wire [7:0] opc = instr_r[7:0];
  wire [7:0] b2 = instr_r[15:8];
  wire [7:0] b3 = instr_r[23:16];
  wire [3:0] f_wsel = b2[`BMI_F_WSEL_HI:`BMI_F_WSEL_LO];
  wire [2:0] f_bit = b2[`BMI_F_BIT_HI:`BMI_F_BIT_LO];
  wire f_sel = b2[`BMI_F_SEL];
  wire go = wr_en && (idx == `BMI_IDX_CTRL) && pwdata[`BMI_CTRL_GO] &&
            (state_r == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  reg dec_ok;
  reg [1:0] dec_op;
  reg [1:0] dec_bytes;
  reg [2:0] dec_cyc;

  always @* begin
    dec_ok = 1'b1;
    dec_op = `BMI_OP_CMP;
    dec_bytes = `BMI_BYTES_2;
    dec_cyc = `BMI_CYC_2;
    case (opc)
      `BMI_OPC_CMP: begin
        dec_bytes = `BMI_BYTES_CMP;
        dec_cyc = `BMI_CYC_CMP;
        dec_ok = ~f_sel;
      end
      `BMI_OPC_CPL: begin
        dec_op = `BMI_OP_CPL;
        dec_ok = ~f_sel;
      end
      `BMI_OPC_CLRSET: begin
        // Selector bit splits clear from set under one opcode
        dec_op = f_sel ? `BMI_OP_SET : `BMI_OP_CLR;
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit unit

  wire [7:0] bu_res;
  wire bu_we;
  wire [7:0] bu_cc;

  bmi_bitop u_bitop (
    .op(op_r),
    .bitpos(bit_r),
    .dst(dst_r),
    .src(src_r),
    .cc_in(cc_r),
    .res(bu_res),
    .dst_we(bu_we),
    .cc_out(bu_cc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and register space

  // Register array has no reset; software initialises what it uses
  always @(posedge pclk) begin
    if (wr_en && mem_hit) begin
      regs_r[idx[7:0]] <= pwdata[7:0];
    end
    // Both may land at once; write-back comes last and wins its byte
    if (state_r == ST_WB && bu_we) begin
      regs_r[dst_addr_r] <= bu_res;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      op_r <= `BMI_OP_CMP;
      bit_r <= 3'h0;
      dst_addr_r <= 8'h00;
      dst_r <= 8'h00;
      src_r <= 8'h00;
      cc_r <= `BMI_CC_RST;
      instr_r <= 24'h000000;
      ill_r <= 1'b0;
      bytes_r <= 2'h0;
      cyc_r <= 3'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (wr_en && idx == `BMI_IDX_INSTR && state_r == ST_IDLE) begin
        instr_r <= pwdata[23:0];
      end
      // Flag writes lose to a finishing instruction in the same cycle
      if (state_r == ST_WB) begin
        cc_r <= bu_cc;
      end else if (wr_en && cc_hit) begin
        cc_r <= pwdata[7:0];
      end
      case (state_r)
        ST_IDLE: begin
          if (go) begin
            ill_r <= ~dec_ok;
            if (dec_ok) begin
              op_r <= dec_op;
              bit_r <= f_bit;
              dst_addr_r <= {`BMI_WREG_BASE, f_wsel};
              dst_r <= regs_r[{`BMI_WREG_BASE, f_wsel}];
              // Every operation loads src_r from the register byte three names; only compare uses it
              src_r <= regs_r[b3];
              bytes_r <= dec_bytes;
              cyc_r <= dec_cyc;
              cnt_r <= dec_cyc - 3'h2;
              state_r <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (cnt_r == 3'h0) begin
            state_r <= ST_WB;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ST_WB: begin
          done <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer, zero wait states

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= 32'h00000000;
      if (setup && !pwrite) begin
        if (cc_hit) begin
          prdata <= {24'h000000, cc_r};
        end else if (mem_hit) begin
          prdata <= {24'h000000, regs_r[idx[7:0]]};
        end else if (idx == `BMI_IDX_INSTR) begin
          prdata <= {8'h00, instr_r};
        end else if (idx == `BMI_IDX_STAT) begin
          prdata <= {20'h00000, 1'b0, cyc_r, 2'b00, bytes_r, 1'b0,
                     (state_r == ST_WB), ill_r, (state_r != ST_IDLE)};
        end
      end
    end
  end

endmodule // bmi_core

// File: hw/bmi_map.vh
// Purpose: Register indexes, flag positions, opcodes and counts.
// Assumes: Included once per design file.
// Notes: Byte address on APB is four times a register index.
`ifndef BMI_MAP_VH
`define BMI_MAP_VH

// Register indexes (byte address = index * 4)
`define BMI_IDX_W 10
`define BMI_IDX_CC 10'h0d5
`define BMI_IDX_INSTR 10'h100
`define BMI_IDX_CTRL 10'h101
`define BMI_IDX_STAT 10'h102
`define BMI_WREG_BASE 4'hc

// Condition-code bit positions
`define BMI_CC_C 7
`define BMI_CC_Z 6
`define BMI_CC_S 5
`define BMI_CC_V 4
`define BMI_CC_D 3
`define BMI_CC_H 2
`define BMI_CC_RST 8'h00

// Second-byte fields
`define BMI_F_WSEL_HI 7
`define BMI_F_WSEL_LO 4
`define BMI_F_BIT_HI 3
`define BMI_F_BIT_LO 1
`define BMI_F_SEL 0

// Opcodes
`define BMI_OPC_CMP 8'h17
`define BMI_OPC_CPL 8'h57
`define BMI_OPC_CLRSET 8'h77

// Operation codes inside the block
`define BMI_OP_CMP 2'h0
`define BMI_OP_CPL 2'h1
`define BMI_OP_CLR 2'h2
`define BMI_OP_SET 2'h3

// Byte and cycle counts
`define BMI_BYTES_CMP 2'h3
`define BMI_BYTES_2 2'h2
`define BMI_CYC_CMP 3'h6
`define BMI_CYC_2 3'h4

// Control and status bits
`define BMI_CTRL_GO 0
`define BMI_STAT_BUSY 0
`define BMI_STAT_ILL 1
`define BMI_STAT_DONE 2
`define BMI_STAT_BYTES_LO 4
`define BMI_STAT_CYC_LO 8

`endif

// File: tb/bmi_core_asserts.sv
// Purpose: Port checks for bmi_core
// Assumes: No start while busy
// Notes: Mirrors opcode and selector
module bmi_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire done
);
  timeunit 1ns;
  timeprecision 1ns;
  wire st = psel && !penable;
  wire [9:0] ix = paddr[11:2];
  wire go = st && pwrite && ix == 10'h101 && pwdata[0];
  logic [8:0] ins_r;
  // Opcode kept, as done alone cannot tell N
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ins_r <= 9'h000;
    else if (st && pwrite && ix == 10'h100) ins_r <= pwdata[8:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////
  apb_ready_a: assert property (st |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready long");
  unmapped_err_a: assert property (st && ix > 10'h102 |=> pslverr)
    else $error("no error");
  mapped_ok_a: assert property (st && ix <= 10'h102 |=> !pslverr)
    else $error("false error");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("data idle");
  cmp_cycles_a:
    assert property (go && ins_r == 9'h017 |-> ##7 done)
    else $error("compare length");
  short_cycles_a:
    assert property (go && (ins_r == 9'h057 || ins_r[7:0] == 8'h77)
      |-> ##5 done) else $error("short length");
  bad_sel_a:
    assert property (go && ins_r[8] &&
      (ins_r[7:0] == 8'h17 || ins_r[7:0] == 8'h57) |=> !done [*8])
    else $error("bad selector ran");
  cover property (go);
  cover property (done);
  cover property (pslverr);
endmodule // bmi_chk

bind bmi_core bmi_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .done);

// File: tb/tb_bmi_core.sv
// Purpose: Self-checking bench for bmi_core
// Assumes: One APB transfer at a time
// Notes: Byte address is index times four
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  miscompares++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_bmi_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic err;
  int miscompares, cmp_count;
  bmi_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .done);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////
  task test_done;
    $display("compares %0d bad %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Request held until pready, released only after it
  task xfer(input [11:0] a, input w, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rc(input [11:0] a, input [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CK(q, e)
  endtask
  task ex(input [23:0] i);
    wr(12'h400, {8'h00, i});
    wr(12'h404, 32'h1);
    do @(posedge pclk); while (done !== 1'b1);
  endtask
  // Watchdog; run needs under two hundred cycles
  initial begin
    repeat (2000) @(posedge pclk);
    miscompares++;
    test_done;
  end
  ////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(12'h354, 32'h0);
    wr(12'h304, 32'h7);
    wr(12'h354, 32'hff);
    ex(24'h001257);
    rc(12'h304, 32'h5);
    rc(12'h354, 32'h9f);
    rc(12'h408, 32'h420);
    wr(12'h33c, 32'h2);
    wr(12'h354, 32'h0);
    ex(24'h00f257);
    rc(12'h33c, 32'h0);
    rc(12'h354, 32'h40);
    $display("end complement");
    ex(24'h001077);
    rc(12'h304, 32'h4);
    ex(24'h001777);
    rc(12'h304, 32'hc);
    rc(12'h354, 32'h40);
    $display("end clear set");
    wr(12'h304, 32'h7);
    wr(12'h004, 32'h1);
    wr(12'h354, 32'hff);
    ex(24'h011217);
    rc(12'h354, 32'h9f);
    rc(12'h304, 32'h7);
    rc(12'h004, 32'h1);
    rc(12'h408, 32'h630);
    wr(12'h004, 32'h3);
    wr(12'h354, 32'h20);
    ex(24'h011217);
    rc(12'h354, 32'h40);
    $display("end compare");
    // Selector set on complement is refused
    wr(12'h400, 32'h001357);
    wr(12'h404, 32'h1);
    xfer(12'h408, 1'b0, 32'h0);
    `CK(q[1:0], 2'h2)
    rc(12'h304, 32'h7);
    // Selector set on compare is refused too
    wr(12'h400, 32'h011317);
    wr(12'h404, 32'h1);
    xfer(12'h408, 1'b0, 32'h0);
    `CK(q[1:0], 2'h2)
    rc(12'h354, 32'h40);
    xfer(12'h40c, 1'b0, 32'h0);
    `CK({err, q}, 33'h100000000)
    $display("end refusals");
    test_done;
  end
endmodule // tb_bmi_core
